/* hdl/tcd_diag_seq.v */
// Purpose: Runs the selected diagnostic tests one after another
// Assumes: Test engines answer each request with a one-cycle done pulse
// Notes:   Order is RAM, loop, DMA; selection is frozen at start
`timescale 1ns/1ps

module tcd_diag_seq (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       start,
  input  wire [2:0] sel,
  input  wire [2:0] test_done,
  output reg  [2:0] test_req_q,
  output reg        busy_q,
  output reg        done_q
);

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_RUN  = 3'b010;
  localparam [2:0] S_DONE = 3'b100;

  reg [2:0] state_q;
  reg [2:0] pend_q;

  // ==========================================================
  // Lowest pending test wins
  function [2:0] lowest;
    input [2:0] v;
    begin
      lowest = v & (~v + 3'h1);
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= S_IDLE;
      pend_q     <= 3'h0;
      test_req_q <= 3'h0;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (start) begin
            pend_q  <= sel;
            busy_q  <= 1'b1;
            state_q <= S_RUN;
          end
        end
        S_RUN: begin
          if (test_req_q == 3'h0) begin
            if (pend_q == 3'h0) begin
              state_q <= S_DONE;
            end else begin
              test_req_q <= lowest(pend_q);
            end
          end else if ((test_done & test_req_q) != 3'h0) begin
            pend_q     <= pend_q & ~test_req_q;
            test_req_q <= 3'h0;
          end
        end
        S_DONE: begin
          done_q  <= 1'b1;
          busy_q  <= 1'b0;
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // tcd_diag_seq

/* hdl/tcd_map.vh */
// Purpose: Register map, field positions and reset values of the token controller diag block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef TCD_MAP_VH
`define TCD_MAP_VH

// ==========================================================
// Register byte offsets
`define TCD_OFF_DIAG_CTRL   8'h00
`define TCD_OFF_FRAME_STAT  8'h04
`define TCD_OFF_MODE_STAT   8'h08
`define TCD_OFF_IRQ_STAT    8'h0C
`define TCD_OFF_IRQ_MASK    8'h10
`define TCD_OFF_BUF_CFG     8'h14

// ==========================================================
// diag_control fields
`define TCD_DC_GO           0
`define TCD_DC_RAM          1
`define TCD_DC_LOOP         2
`define TCD_DC_DMA          3
`define TCD_DC_ADDR_DRIVE_ENABLE         4
`define TCD_DC_DIAGEN       7
`define TCD_DC_WMASK        8'h9F
`define TCD_DC_RESET        8'h00

// ==========================================================
// frame_status fields
`define TCD_FS_LAST         7
`define TCD_FS_ACKP         6
`define TCD_FS_LEN8         5
`define TCD_FS_ZERO         4

// ==========================================================
// mode status, interrupt and buffer fields
`define TCD_MS_ISOL         0
`define TCD_MS_DIAG         1
`define TCD_IRQ_MODE        0
`define TCD_IRQ_DDONE       1
`define TCD_IRQ_W           2
`define TCD_BUF_RESET       4'h0
`define TCD_BUF_LEN_RESET   11'h040
`define TCD_BUF_UNIT_SHIFT  6
`define TCD_LEN_EIGHT       16'h0008

`endif

/* hdl/tcd_top.v */
// Purpose: Diagnostic mode control, address drive and frame status of a token controller
// Assumes: Frame engine signals share pclk; dma_ack_n arrives from a pin
// Notes:   APB slave answers with pready one cycle after setup
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "tcd_map.vh"

module tcd_top #(
  parameter ADDR_W = 16
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [7:0]        paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  output reg               irq_q,
  input  wire              dma_ack_n,
  input  wire [ADDR_W-1:0] dma_addr,
  output reg  [ADDR_W-1:0] addr_q,
  output reg  [ADDR_W-1:0] addr_oe,
  input  wire              tx_active,
  input  wire              tx_frame_start,
  input  wire [15:0]       tx_frame_len,
  input  wire              last_frame_set,
  input  wire              rx_ack_req,
  input  wire              ack_tx_done,
  input  wire [2:0]        test_done,
  output wire [2:0]        test_req_q,
  output reg               isolate_q,
  output reg  [10:0]       buf_len_bytes_q
);

  localparam [2:0] M_OFF  = 3'b001;
  localparam [2:0] M_DIAG = 3'b010;
  localparam [2:0] M_ISOL = 3'b100;

  reg  [7:0]          diag_control_q;
  reg  [7:0]          diag_control_d;
  reg  [2:0]          mode_q;
  reg                 diag_state_q;
  reg                 launched_q;
  reg  [`TCD_IRQ_W-1:0] irq_stat_q;
  reg  [`TCD_IRQ_W-1:0] irq_mask_q;
  reg  [3:0]          buf_code_q;
  reg                 last_q;
  reg                 ackp_q;
  reg                 len8_q;
  reg  [2:0]          ack_sync_q;
  reg                 ack_n_q;
  reg  [31:0]         rdata_d;
  reg                 rerr_d;
  wire                seq_busy;
  wire                seq_done;
  wire                diag_active;
  wire                seq_start;
  wire                wr_fire;
  wire                mode_event;
  wire [7:0]          frame_status;
  wire                wr_ctrl;
  wire                wr_irq_stat;
  wire                wr_irq_mask;
  wire                wr_buf_cfg;
  wire [`TCD_IRQ_W-1:0] irq_clr;
  wire [`TCD_IRQ_W-1:0] irq_set;
  wire [10:0]         buf_len_d;

  // ==========================================================
  // Register decode
  function [7:0] reg_hit;
    input [7:0] a;
    begin
      reg_hit = {2'b00,
                 a == `TCD_OFF_BUF_CFG,
                 a == `TCD_OFF_IRQ_MASK,
                 a == `TCD_OFF_IRQ_STAT,
                 a == `TCD_OFF_MODE_STAT,
                 a == `TCD_OFF_FRAME_STAT,
                 a == `TCD_OFF_DIAG_CTRL};
    end
  endfunction

  // Writes land only in the access cycle that pready completes
  assign wr_fire     = psel & penable & pwrite & pready;
  assign wr_ctrl     = wr_fire & (reg_hit(paddr) == 8'h01);
  assign wr_irq_stat = wr_fire & (reg_hit(paddr) == 8'h08);
  assign wr_irq_mask = wr_fire & (reg_hit(paddr) == 8'h10);
  assign wr_buf_cfg  = wr_fire & (reg_hit(paddr) == 8'h20);

  // ==========================================================
  // APB slave, one wait-free access phase after setup
  always @* begin
    rdata_d = 32'h0000_0000;
    rerr_d  = 1'b0;
    case (reg_hit(paddr))
      8'h01:   rdata_d[7:0] = diag_control_q;
      8'h02:   rdata_d[7:0] = frame_status;
      8'h04:   rdata_d[1:0] = {diag_state_q, isolate_q};
      8'h08:   rdata_d[`TCD_IRQ_W-1:0] = irq_stat_q;
      8'h10:   rdata_d[`TCD_IRQ_W-1:0] = irq_mask_q;
      8'h20:   rdata_d[3:0] = buf_code_q;
      // Unmapped offsets read as zero and flag an error
      default: rerr_d = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
      pslverr <= rerr_d;
      pready  <= 1'b1;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // Control register; hardware clear of go loses to a host set
  always @* begin
    diag_control_d = diag_control_q;
    if (seq_done) begin
      diag_control_d[`TCD_DC_GO] = 1'b0;
    end
    if (wr_ctrl) begin
      diag_control_d = (pwdata[7:0] & `TCD_DC_WMASK) |
                       (diag_control_d & {7'h00, pwdata[`TCD_DC_GO]});
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_control_q <= `TCD_DC_RESET;
    end else begin
      diag_control_q <= diag_control_d;
    end
  end

  // ==========================================================
  // Mode tracking
  assign diag_active = diag_control_q[`TCD_DC_DIAGEN] & diag_state_q;
  // Leave diag mode only with the sequencer idle and no launch pending
  assign mode_event  = mode_q[1] & ~diag_control_q[`TCD_DC_DIAGEN] &
                       ~seq_busy & ~seq_start;

  // Confirming flag sets one cycle after the enable and clears only on mode_event

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q       <= M_OFF;
      diag_state_q <= 1'b0;
      isolate_q    <= 1'b0;
    end else begin
      case (mode_q)
        M_OFF, M_ISOL: begin
          if (diag_control_q[`TCD_DC_DIAGEN]) begin
            mode_q       <= M_DIAG;
            diag_state_q <= 1'b1;
            isolate_q    <= 1'b0;
          end
        end
        M_DIAG: begin
          if (mode_event) begin
            mode_q       <= M_ISOL;
            diag_state_q <= 1'b0;
            isolate_q    <= 1'b1;
          end
        end
        default: begin
          mode_q <= M_OFF;
        end
      endcase
    end
  end

  // ==========================================================
  // Test launch; one run per setting of go
  // A go bit still set after done must not relaunch the same run
  assign seq_start = diag_active & diag_control_q[`TCD_DC_GO] &
                     ~launched_q & ~seq_busy;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      launched_q <= 1'b0;
    end else if (seq_start) begin
      launched_q <= 1'b1;
    end else if (!diag_control_q[`TCD_DC_GO]) begin
      launched_q <= 1'b0;
    end
  end

  tcd_diag_seq u_seq (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (seq_start),
    .sel        ({diag_control_q[`TCD_DC_DMA],
                  diag_control_q[`TCD_DC_LOOP],
                  diag_control_q[`TCD_DC_RAM]}),
    .test_done  (test_done),
    .test_req_q (test_req_q),
    .busy_q     (seq_busy),
    .done_q     (seq_done)
  );

  // ==========================================================
  // Interrupts, write one to clear; new events win over clear
  assign irq_clr = wr_irq_stat ? pwdata[`TCD_IRQ_W-1:0] : {`TCD_IRQ_W{1'b0}};
  assign irq_set = {seq_done, mode_event};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= {`TCD_IRQ_W{1'b0}};
      irq_mask_q <= {`TCD_IRQ_W{1'b0}};
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      if (wr_irq_mask) begin
        irq_mask_q <= pwdata[`TCD_IRQ_W-1:0];
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ==========================================================
  // Address drive; acknowledge pin filtered by three stages
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_sync_q <= 3'b111;
      ack_n_q    <= 1'b1;
      addr_q     <= {ADDR_W{1'b0}};
      addr_oe    <= {ADDR_W{1'b0}};
    end else begin
      ack_sync_q <= {ack_sync_q[1:0], dma_ack_n};
      // Filtered level moves only when two stages agree; short glitches vanish
      if (ack_sync_q[1] == ack_sync_q[2]) begin
        ack_n_q <= ack_sync_q[2];
      end
      addr_q  <= dma_addr;
      addr_oe <= {ADDR_W{diag_control_q[`TCD_DC_ADDR_DRIVE_ENABLE] | ~ack_n_q}};
    end
  end

  // ==========================================================
  // Frame status flags; sets win over clears
  assign frame_status = {last_q, ackp_q, len8_q, 1'b0, buf_code_q};
  // Code 0 to 15 maps to 1 to 16 units of 64 bytes
  assign buf_len_d    = ({7'h00, buf_code_q} + 11'h001) << `TCD_BUF_UNIT_SHIFT;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q          <= 1'b0;
      ackp_q          <= 1'b0;
      len8_q          <= 1'b0;
      buf_code_q      <= `TCD_BUF_RESET;
      buf_len_bytes_q <= `TCD_BUF_LEN_RESET;
    end else begin
      if (last_frame_set) begin
        last_q <= 1'b1;
      end else if (tx_frame_start) begin
        last_q <= 1'b0;
      end
      if (rx_ack_req) begin
        ackp_q <= 1'b1;
      end else if (ack_tx_done) begin
        ackp_q <= 1'b0;
      end
      // Kept until the next frame start so software can still read it
      if (tx_active && tx_frame_len == `TCD_LEN_EIGHT) begin
        len8_q <= 1'b1;
      end else if (tx_frame_start) begin
        len8_q <= 1'b0;
      end
      if (wr_buf_cfg) begin
        buf_code_q <= pwdata[3:0];
      end
      buf_len_bytes_q <= buf_len_d;
    end
  end

endmodule // tcd_top

/* tb/tb.sv */
// Purpose: Self-checking bench of the diag block
// Assumes: APB answers with pready, bounded wait
// Notes:   Engine delay switched between prompt and slow
`timescale 1ns/1ps

module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dma_ack_n = 1;
  logic [7:0] paddr = 0, dly = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, irq_q, isolate_q, er;
  logic [15:0] dma_addr = 16'hA5C3, addr_q, addr_oe, tx_frame_len = 0;
  logic tx_active = 0, tx_frame_start = 0, last_frame_set = 0, rx_ack_req = 0;
  logic ack_tx_done = 0;
  logic [2:0] test_done, test_req_q, pq = 0;
  logic [2:0] seq[$];
  logic [10:0] buf_len_bytes_q;
  int failures = 0, cmp_count = 0;

  tcd_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq_q, .dma_ack_n, .dma_addr, .addr_q, .addr_oe, .tx_active,
    .tx_frame_start, .tx_frame_len, .last_frame_set, .rx_ack_req, .ack_tx_done,
    .test_done, .test_req_q, .isolate_q, .buf_len_bytes_q);
  tcd_eng_model u_eng (.pclk, .presetn, .dly, .test_req_q, .test_done);

  initial forever #2.5 pclk = ~pclk;
  // Log each new request to check test order
  always @(posedge pclk) begin
    if (test_req_q != pq && test_req_q != 0) seq.push_back(test_req_q);
    pq <= test_req_q;
  end

  // ==========================================================
  // Shared helpers
  task chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cyc(input int n); repeat (n) @(posedge pclk); endtask
  // Waits for pready without a limit; only the watchdog ends a hang
  task rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask

  // ==========================================================
  // Scenarios
  task t_regs;
    rw(0, 8'h00, 0); chk(rd, 0);
    rw(0, 8'h04, 0); chk(rd, 0);
    chk(buf_len_bytes_q, 64);
    rw(0, 8'h18, 0); chk(er, 1); chk(rd, 0);
    rw(1, 8'h14, 32'hF); cyc(2); chk(buf_len_bytes_q, 1024);
    rw(0, 8'h04, 0); chk(rd[3:0], 4'hF);
    rw(1, 8'h14, 32'h3); cyc(2); chk(buf_len_bytes_q, 256);
  endtask
  task t_addr;
    chk(addr_oe, 0);
    dma_ack_n <= 0; dma_addr <= 16'h3C5A; cyc(6);
    chk(addr_oe, 16'hFFFF); chk(addr_q, 16'h3C5A);
    dma_ack_n <= 1; cyc(6); chk(addr_oe, 0);
    rw(1, 8'h00, 32'h10); cyc(2); chk(addr_oe, 16'hFFFF);
    rw(1, 8'h00, 0);
  endtask
  task t_diag;
    int n;
    rw(1, 8'h00, 32'h80); cyc(4); rw(0, 8'h08, 0); chk(rd[1], 1);
    rw(1, 8'h10, 32'h3);
    seq = {}; dly <= 3;
    rw(1, 8'h00, 32'h8F);
    n = 0;
    do begin rw(0, 8'h00, 0); n++; end while (rd[0] !== 0 && n < 60);
    chk(rd[0], 0);
    chk({seq[0], seq[1], seq[2]}, 9'o124);
    rw(0, 8'h0C, 0); chk(rd[1], 1); chk(irq_q, 1);
    rw(1, 8'h0C, 32'h2); cyc(2); chk(irq_q, 0);
    seq = {}; dly <= 40;
    rw(1, 8'h00, 32'h85); cyc(8); rw(1, 8'h00, 32'h05);
    cyc(10); chk(isolate_q, 0);
    n = 0;
    while (isolate_q !== 1 && n < 200) begin @(posedge pclk); n++; end
    chk(isolate_q, 1); chk(seq.size(), 1); chk(seq[0], 2);
    rw(0, 8'h0C, 0); chk(rd[0], 1);
    rw(1, 8'h10, 0); cyc(2); chk(irq_q, 0);
    rw(1, 8'h10, 32'h1); cyc(2); chk(irq_q, 1);
    rw(1, 8'h0C, 32'h1); cyc(2); chk(irq_q, 0);
    rw(1, 8'h00, 32'h03); cyc(10); chk(test_req_q, 0);
    rw(1, 8'h00, 0);
  endtask
  task t_frame;
    tx_frame_len <= 16'h0009; tx_active <= 1; cyc(3);
    rw(0, 8'h04, 0); chk(rd[5], 0);
    tx_frame_len <= 16'h0008; cyc(3);
    rw(0, 8'h04, 0); chk(rd[5], 1);
    tx_active <= 0;
    rx_ack_req <= 1; @(posedge pclk); rx_ack_req <= 0; cyc(2);
    rw(0, 8'h04, 0); chk(rd[6], 1);
    ack_tx_done <= 1; @(posedge pclk); ack_tx_done <= 0; cyc(2);
    rw(0, 8'h04, 0); chk(rd[6], 0);
    last_frame_set <= 1; @(posedge pclk); last_frame_set <= 0; cyc(20);
    rw(0, 8'h04, 0); chk(rd[7], 1);
    tx_frame_start <= 1; @(posedge pclk); tx_frame_start <= 0; cyc(2);
    rw(0, 8'h04, 0); chk(rd[7:4], 0);
  endtask

  // ==========================================================
  // Verdict and run
  task give_verdict;
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    cyc(6); presetn <= 1;
    t_regs; t_addr; t_diag; t_frame;
    give_verdict;
  end
  initial begin
    #200000;
    failures++;
    give_verdict;
  end
endmodule // tb

/* tb/tcd_eng_model.sv */
// Purpose: Test engine stand-in answering diag requests with done pulses
// Assumes: Requests are one-hot levels held until their done pulse
// Notes:   Delay is an input so one run covers prompt and slow engines
`timescale 1ns/1ps

module tcd_eng_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] dly,
  input  wire logic [2:0] test_req_q,
  output logic      [2:0] test_done
);
  logic [7:0] cnt_q;
  logic [2:0] srv_q;

  // ==========================================================
  // Answer once per request; srv_q blocks a repeat pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= 8'h00;
      srv_q     <= 3'h0;
      test_done <= 3'h0;
    end else begin
      test_done <= 3'h0;
      if (test_req_q == 3'h0) begin
        cnt_q <= 8'h00;
        srv_q <= 3'h0;
      end else if (test_req_q != srv_q) begin
        if (cnt_q >= dly) begin
          test_done <= test_req_q;
          srv_q     <= test_req_q;
          cnt_q     <= 8'h00;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end
endmodule // tcd_eng_model

/* tb/tcd_props.sv */
// Purpose: Port-level checks of the diag block
// Assumes: Single pclk domain, presetn active low
// Notes:   Bound into tcd_top below
`timescale 1ns/1ps

module tcd_props #(
  parameter ADDR_W = 16
) (
  input logic              pclk,
  input logic              presetn,
  input logic              psel,
  input logic              penable,
  input logic              pwrite,
  input logic [7:0]        paddr,
  input logic [31:0]       pwdata,
  input logic [31:0]       prdata,
  input logic              pready,
  input logic              pslverr,
  input logic              irq_q,
  input logic              dma_ack_n,
  input logic [ADDR_W-1:0] dma_addr,
  input logic [ADDR_W-1:0] addr_q,
  input logic [ADDR_W-1:0] addr_oe,
  input logic              tx_active,
  input logic              tx_frame_start,
  input logic              last_frame_set,
  input logic [15:0]       tx_frame_len,
  input logic              rx_ack_req,
  input logic              ack_tx_done,
  input logic              isolate_q,
  input logic [2:0]        test_done,
  input logic [2:0]        test_req_q,
  input logic [10:0]       buf_len_bytes_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_fs_rd; s_setup ##0 (!pwrite && paddr == 8'h04); endsequence
  sequence s_ack_low; !dma_ack_n [*5]; endsequence

  AST_PREADY: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  AST_ERR: assert property (pslverr |-> pready) else $error("pslverr without pready");
  AST_FS_ZERO: assert property (s_fs_rd |=> prdata[31:8] == 0 && !prdata[4])
    else $error("frame status fixed bits wrong");
  AST_BUF_LEN: assert property (buf_len_bytes_q[5:0] == 0 && buf_len_bytes_q >= 64
    && buf_len_bytes_q <= 1024) else $error("buffer length out of range");
  AST_OE_ACK: assert property (s_ack_low |=> &addr_oe) else $error("ack low not driving");
  AST_OE_ALL: assert property (addr_oe == 0 || &addr_oe) else $error("partial drive");
  AST_ADDR: assert property (|addr_oe |-> addr_q == $past(dma_addr))
    else $error("address output wrong");
  AST_REQ_HOT: assert property ($onehot0(test_req_q)) else $error("two tests at once");
  AST_REQ_HOLD: assert property (test_req_q != 0 && (test_req_q & test_done) == 0
    |=> $stable(test_req_q)) else $error("request dropped early");
  AST_REQ_DROP: assert property ((test_req_q & test_done) != 0
    |=> (test_req_q & $past(test_done)) == 0) else $error("request held after done");
  AST_ISO_IDLE: assert property ($rose(isolate_q) |-> test_req_q == 0)
    else $error("isolate while test runs");
endmodule // tcd_props

bind tcd_top tcd_props #(.ADDR_W(ADDR_W)) u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_q, .dma_ack_n, .dma_addr,
  .addr_q, .addr_oe, .tx_active, .tx_frame_start, .last_frame_set, .tx_frame_len,
  .rx_ack_req, .ack_tx_done, .isolate_q, .test_done, .test_req_q, .buf_len_bytes_q);
